// ---- rtl/mfs_supervisor.v ----
// motor fault supervisor: config registers, lock checks, supply limits, fault output
// Function
// [R1] retry field picks 100 ms, 500 ms, 1 s, then plus one second per code
// [R2] reaction 0 latches lock fault and holds fault_out_n low until cleared
// [R3] reaction 1 clears lock fault by itself after retry interval
// [R4] reaction 2 only reports lock in status, no protective action
// [R5] reaction 3 performs no lock detection at all
// [R6] overspeed check evaluated only while its enable bit is one
// [R7] weak back-EMF check evaluated only while its enable bit is one
// [R8] absent-motor check evaluated only while its enable bit is one
// [R9] overspeed limit 130 percent of max speed plus ten per code
// [R10] weak back-EMF fault when emf/supply below 1,2,3,5,8,10,12,15 percent
// [R11] absent-motor current limit from 32-step scale, 7.5 to 100 percent
// [R12] undervoltage limit: none, then 5,10,12,15,18,20,25 percent of base
// [R13] undervoltage reaction 0 latches, 1 clears when supply back in bounds
// [R14] overvoltage limit 60 percent plus five per code, code 7 maximum
// [R15] overvoltage reaction 0 latches, 1 clears when supply back in bounds
// [R16] retry timer starts at lock fault; restart only when expired and fault-free
// [R17] fields reset to zero; reserved bits read back as written, no effect
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mfs_defs.vh"

module mfs_supervisor #(
    parameter TICK_CYCLES = `MFS_TICK_CYCLES,
    parameter MW          = 16
) (
    input  wire          sys_clk,
    input  wire          nrst,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire [MW-1:0] speed_meas,
    input  wire [MW-1:0] speed_max,
    input  wire [MW-1:0] emf_meas,
    input  wire [MW-1:0] supply_meas,
    input  wire [MW-1:0] current_meas,
    input  wire [MW-1:0] current_base,
    input  wire [MW-1:0] voltage_base,
    input  wire          motor_running,
    output reg           fault_out_n,
    output reg           run_permit,
    output reg           irq
);

// ****************************************
// reset release
// ****************************************
reg rst_meta;
reg rst_n;
always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        rst_meta <= 1'b0;
        rst_n    <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n    <= rst_meta;
    end
end

// ****************************************
// helper functions
// ****************************************
// value * pct_x10 / 1000, product widened to avoid overflow
function [MW-1:0] mfs_scale;
    input [MW-1:0] value;
    input [10:0]   pct_x10;
    reg   [MW+10:0] prod;
    reg   [MW+10:0] quot;
    begin
        prod      = value * pct_x10;
        quot      = prod / {{MW{1'b0}}, 11'd1000};
        mfs_scale = quot[MW-1:0];
    end
endfunction

function [10:0] mfs_absent_pct;
    input [4:0] code;
    begin
        case (code)
            5'h00: mfs_absent_pct = 11'd75;
            5'h01: mfs_absent_pct = 11'd80;
            5'h02: mfs_absent_pct = 11'd85;
            5'h03: mfs_absent_pct = 11'd90;
            5'h04: mfs_absent_pct = 11'd95;
            5'h05: mfs_absent_pct = 11'd100;
            5'h06: mfs_absent_pct = 11'd110;
            5'h07: mfs_absent_pct = 11'd120;
            5'h08: mfs_absent_pct = 11'd130;
            5'h09: mfs_absent_pct = 11'd140;
            5'h0A: mfs_absent_pct = 11'd150;
            5'h0B: mfs_absent_pct = 11'd160;
            5'h0C: mfs_absent_pct = 11'd170;
            5'h0D: mfs_absent_pct = 11'd180;
            5'h0E: mfs_absent_pct = 11'd200;
            5'h0F: mfs_absent_pct = 11'd225;
            5'h10: mfs_absent_pct = 11'd250;
            5'h11: mfs_absent_pct = 11'd275;
            5'h12: mfs_absent_pct = 11'd300;
            5'h13: mfs_absent_pct = 11'd350;
            5'h14: mfs_absent_pct = 11'd400;
            5'h15: mfs_absent_pct = 11'd450;
            5'h16: mfs_absent_pct = 11'd500;
            5'h17: mfs_absent_pct = 11'd550;
            5'h18: mfs_absent_pct = 11'd600;
            5'h19: mfs_absent_pct = 11'd700;
            5'h1A: mfs_absent_pct = 11'd750;
            5'h1B: mfs_absent_pct = 11'd800;
            5'h1C: mfs_absent_pct = 11'd850;
            5'h1D: mfs_absent_pct = 11'd900;
            5'h1E: mfs_absent_pct = 11'd950;
            default: mfs_absent_pct = 11'd1000;
        endcase
    end
endfunction

// ****************************************
// registers and apb slave
// ****************************************
reg  [31:0]            lock_fault_setup;
reg  [31:0]            lock_and_supply_limits;
reg  [`MFS_ST_W-1:0]   status;
reg  [`MFS_ST_W-1:0]   irq_enable;
reg  [`MFS_ST_W-1:0]   clear_pulse;
reg                    fault_clear;
wire                   wr_access = psel && penable && pwrite && pready;
wire                   rd_setup  = psel && !penable && !pwrite;
wire                   addr_ok   = (paddr == `MFS_OFF_LOCK_SETUP) || (paddr == `MFS_OFF_LIMITS)
                                || (paddr == `MFS_OFF_STATUS) || (paddr == `MFS_OFF_CLEAR)
                                || (paddr == `MFS_OFF_IRQ_EN) || (paddr == `MFS_OFF_CTRL);

// no wait state: setup, then access answered with pready in its first cycle
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        lock_fault_setup       <= `MFS_RESET_VALUE; // see [R17]
        lock_and_supply_limits <= `MFS_RESET_VALUE; // see [R17]
        irq_enable             <= {`MFS_ST_W{1'b0}};
        clear_pulse            <= {`MFS_ST_W{1'b0}};
        fault_clear            <= 1'b0;
        pready                 <= 1'b0;
        pslverr                <= 1'b0;
        prdata                 <= 32'h0000_0000;
    end else begin
        clear_pulse <= {`MFS_ST_W{1'b0}};
        fault_clear <= 1'b0;
        pready      <= psel && !penable;
        pslverr     <= psel && !penable && !addr_ok;
        if (rd_setup) begin
            case (paddr)
                `MFS_OFF_LOCK_SETUP: prdata <= lock_fault_setup;
                `MFS_OFF_LIMITS:     prdata <= lock_and_supply_limits;
                `MFS_OFF_STATUS:     prdata <= {{(32-`MFS_ST_W){1'b0}}, status};
                `MFS_OFF_IRQ_EN:     prdata <= {{(32-`MFS_ST_W){1'b0}}, irq_enable};
                default:             prdata <= 32'h0000_0000;
            endcase
        end
        if (wr_access) begin
            case (paddr)
                // reserved bits stored whole but never decoded
                `MFS_OFF_LOCK_SETUP: lock_fault_setup <= pwdata; // see [R17]
                `MFS_OFF_LIMITS:     lock_and_supply_limits <= pwdata; // see [R17]
                `MFS_OFF_CLEAR:      clear_pulse <= pwdata[`MFS_ST_W-1:0];
                `MFS_OFF_IRQ_EN:     irq_enable <= pwdata[`MFS_ST_W-1:0];
                `MFS_OFF_CTRL:       fault_clear <= pwdata[0];
                default: ;
            endcase
        end
    end
end

// ****************************************
// field decode
// ****************************************
wire [3:0] lock_retry_interval   = lock_fault_setup[`MFS_RETRY_MSB:`MFS_RETRY_LSB];
wire [1:0] stall_reaction_select = lock_fault_setup[`MFS_REACT_MSB:`MFS_REACT_LSB];
wire       overspeed_check_on    = lock_and_supply_limits[`MFS_OVS_EN_BIT];
wire       weak_emf_check_on     = lock_and_supply_limits[`MFS_EMF_EN_BIT];
wire       absent_motor_check_on = lock_and_supply_limits[`MFS_ABS_EN_BIT];
wire [2:0] overspeed_threshold   = lock_and_supply_limits[`MFS_OVS_MSB:`MFS_OVS_LSB];
wire [2:0] weak_emf_threshold    = lock_and_supply_limits[`MFS_EMF_MSB:`MFS_EMF_LSB];
wire [4:0] absent_motor_current_threshold = lock_and_supply_limits[`MFS_ABS_MSB:`MFS_ABS_LSB];
wire [2:0] undervoltage_limit    = lock_and_supply_limits[`MFS_UV_MSB:`MFS_UV_LSB];
wire       undervoltage_reaction = lock_and_supply_limits[`MFS_UV_REACT_BIT];
wire [2:0] overvoltage_limit     = lock_and_supply_limits[`MFS_OV_MSB:`MFS_OV_LSB];
wire       overvoltage_reaction  = lock_and_supply_limits[`MFS_OV_REACT_BIT];

reg [10:0] ovs_pct;
reg [10:0] emf_pct;
reg [10:0] uv_pct;
reg [10:0] ov_pct;
always @* begin
    ovs_pct = 11'd1300 + {8'h00, overspeed_threshold} * 11'd100; // see [R9]
    case (weak_emf_threshold) // see [R10]
        3'h0: emf_pct = 11'd10;
        3'h1: emf_pct = 11'd20;
        3'h2: emf_pct = 11'd30;
        3'h3: emf_pct = 11'd50;
        3'h4: emf_pct = 11'd80;
        3'h5: emf_pct = 11'd100;
        3'h6: emf_pct = 11'd120;
        default: emf_pct = 11'd150;
    endcase
    case (undervoltage_limit) // see [R12]
        3'h1: uv_pct = 11'd50;
        3'h2: uv_pct = 11'd100;
        3'h3: uv_pct = 11'd120;
        3'h4: uv_pct = 11'd150;
        3'h5: uv_pct = 11'd180;
        3'h6: uv_pct = 11'd200;
        3'h7: uv_pct = 11'd250;
        default: uv_pct = 11'd0;
    endcase
    ov_pct = 11'd600 + {8'h00, overvoltage_limit} * 11'd50; // see [R14]
end

// ****************************************
// lock and supply checks
// ****************************************
// emf vs supply compared without a divider: emf*1000 < supply*pct
wire [MW+10:0] emf_x1000 = emf_meas * 11'd1000;
wire [MW+10:0] sup_x_pct = supply_meas * emf_pct;
wire ovs_hit  = overspeed_check_on && (speed_meas > mfs_scale(speed_max, ovs_pct)); // see [R6]
wire emf_hit  = weak_emf_check_on && motor_running && (emf_x1000 < sup_x_pct); // see [R7]
wire abs_hit  = absent_motor_check_on && motor_running
              && (current_meas < mfs_scale(current_base, mfs_absent_pct(absent_motor_current_threshold))); // see [R8] [R11]
wire lock_det = (stall_reaction_select != `MFS_REACT_OFF) && (ovs_hit || emf_hit || abs_hit); // see [R5]
wire uv_hit   = (undervoltage_limit != 3'h0) && (supply_meas < mfs_scale(voltage_base, uv_pct)); // see [R12]
// code 7 compares against full base voltage
wire ov_hit   = (overvoltage_limit == 3'h7) ? (supply_meas > voltage_base)
              : (supply_meas > mfs_scale(voltage_base, ov_pct)); // see [R14]

// ****************************************
// retry timer
// ****************************************
localparam integer TICK_LAST_I = TICK_CYCLES - 1;
localparam [17:0]  TICK_LAST   = TICK_LAST_I[17:0];
reg  [17:0] tick_cnt;
reg         tick_ms;
reg  [13:0] retry_ms;
reg         retry_run;
reg  [13:0] retry_target;
always @* begin
    case (lock_retry_interval) // see [R1]
        4'h0: retry_target = `MFS_RETRY_BASE_MS;
        4'h1: retry_target = `MFS_RETRY_STEP1_MS;
        default: retry_target = {10'h000, lock_retry_interval - 4'h1} * `MFS_RETRY_SEC_MS;
    endcase
end

// ****************************************
// fault state
// ****************************************
reg lock_fault;
reg uv_fault;
reg ov_fault;
wire retry_done = retry_run && tick_ms && (retry_ms + 14'h0001 >= retry_target);
wire protect    = (stall_reaction_select == `MFS_REACT_LATCH)
               || (stall_reaction_select == `MFS_REACT_RETRY); // see [R4]

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        tick_cnt   <= 18'h00000;
        tick_ms    <= 1'b0;
        retry_ms   <= 14'h0000;
        retry_run  <= 1'b0;
        lock_fault <= 1'b0;
        uv_fault   <= 1'b0;
        ov_fault   <= 1'b0;
    end else begin
        tick_ms  <= (tick_cnt == TICK_LAST);
        tick_cnt <= (tick_cnt == TICK_LAST) ? 18'h00000 : tick_cnt + 18'h00001;
        // lock: set wins over a clear only while lock_fault is low; once set, a clear wins even with lock_det high
        if (lock_det && protect && !lock_fault) begin
            lock_fault <= 1'b1; // see [R2]
            retry_run  <= (stall_reaction_select == `MFS_REACT_RETRY); // see [R16]
            retry_ms   <= 14'h0000;
        end else if (retry_done) begin
            lock_fault <= 1'b0; // see [R3]
            retry_run  <= 1'b0;
        end else if (fault_clear || !protect) begin
            lock_fault <= 1'b0; // see [R2]
            retry_run  <= 1'b0;
        end else if (retry_run && tick_ms) begin
            retry_ms <= retry_ms + 14'h0001;
        end
        if (uv_hit)
            uv_fault <= 1'b1;
        else if (undervoltage_reaction || fault_clear)
            uv_fault <= 1'b0; // see [R13]
        if (ov_hit)
            ov_fault <= 1'b1;
        else if (overvoltage_reaction || fault_clear)
            ov_fault <= 1'b0; // see [R15]
    end
end

// ****************************************
// status, interrupt and outputs
// ****************************************
wire [`MFS_ST_W-1:0] events = {retry_done, ov_hit, uv_hit, lock_det}; // see [R4]
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        status      <= {`MFS_ST_W{1'b0}};
        irq         <= 1'b0;
        fault_out_n <= 1'b1;
        run_permit  <= 1'b0;
    end else begin
        // a new event beats a clear in the same cycle
        status      <= (status & ~clear_pulse) | events;
        irq         <= |(((status & ~clear_pulse) | events) & irq_enable);
        fault_out_n <= !(lock_fault || uv_fault || ov_fault); // see [R2]
        run_permit  <= !(lock_fault || uv_fault || ov_fault || lock_det && protect); // see [R16]
    end
end

endmodule // mfs_supervisor
`default_nettype wire

// ---- rtl/mfs_defs.vh ----
// offsets, field positions, reset values and timing constants of the fault supervisor
`ifndef MFS_DEFS_VH
`define MFS_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define MFS_OFF_LOCK_SETUP   8'h54
`define MFS_OFF_LIMITS       8'h58
`define MFS_OFF_STATUS       8'h5C
`define MFS_OFF_CLEAR        8'h60
`define MFS_OFF_IRQ_EN       8'h64
`define MFS_OFF_CTRL         8'h68
`define MFS_RESET_VALUE      32'h0000_0000

// ****************************************
// lock_fault_setup fields
// ****************************************
`define MFS_RETRY_MSB        5
`define MFS_RETRY_LSB        2
`define MFS_REACT_MSB        1
`define MFS_REACT_LSB        0
`define MFS_REACT_LATCH      2'h0
`define MFS_REACT_RETRY      2'h1
`define MFS_REACT_REPORT     2'h2
`define MFS_REACT_OFF        2'h3

// ****************************************
// lock_and_supply_limits fields
// ****************************************
`define MFS_OVS_EN_BIT       26
`define MFS_EMF_EN_BIT       25
`define MFS_ABS_EN_BIT       24
`define MFS_OVS_MSB          23
`define MFS_OVS_LSB          21
`define MFS_EMF_MSB          20
`define MFS_EMF_LSB          18
`define MFS_ABS_MSB          17
`define MFS_ABS_LSB          13
`define MFS_UV_MSB           7
`define MFS_UV_LSB           5
`define MFS_UV_REACT_BIT     4
`define MFS_OV_MSB           3
`define MFS_OV_LSB           1
`define MFS_OV_REACT_BIT     0

// ****************************************
// status bits
// ****************************************
`define MFS_ST_LOCK          0
`define MFS_ST_UV            1
`define MFS_ST_OV            2
`define MFS_ST_RETRY_DONE    3
`define MFS_ST_W             4

// ****************************************
// timing: 1 ms tick, retry figures in ms
// ****************************************
`define MFS_CLK_MHZ          250
`define MFS_TICK_US          1000
`define MFS_TICK_CYCLES      (`MFS_CLK_MHZ * `MFS_TICK_US)
`define MFS_RETRY_BASE_MS    14'd100
`define MFS_RETRY_STEP1_MS   14'd500
`define MFS_RETRY_SEC_MS     14'd1000

`endif

// ---- testbench/mfs_chk.sv ----
// port checker for the motor fault supervisor
`timescale 1ns/1ps
`default_nettype none
module mfs_chk #(parameter MW = 16) (
    input wire logic          sys_clk,
    input wire logic          nrst,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic [MW-1:0] supply_meas,
    input wire logic [MW-1:0] voltage_base,
    input wire logic          fault_out_n,
    input wire logic          run_permit,
    input wire logic          irq
);
    localparam int UVT[8] = '{0, 5, 10, 12, 15, 18, 20, 25};
    logic [31:0] lim;
    int          sv, vb, ovp, uvp;
    logic        ov_hit, uv_hit;
    // shadow of the limits word, captured on the same edge as the write lands
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            lim <= 32'h0000_0000;
        else if (psel && penable && pready && pwrite && paddr == 8'h58)
            lim <= pwdata;
    end
    // one unit of margin so rounding in the design never trips these
    always_comb begin
        sv = int'(supply_meas);
        vb = int'(voltage_base);
        ovp = (lim[3:1] == 3'h7) ? 100 : 60 + 5 * int'(lim[3:1]);
        uvp = UVT[lim[7:5]];
        ov_hit = sv * 100 > vb * ovp + 100;
        uv_hit = uvp != 0 && sv * 100 + 100 < vb * uvp;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ACCESS_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_MAPPED_OK: assert property (pready && (paddr == 8'h54 || paddr == 8'h58) |-> !pslverr)
        else $error("mapped register refused");
    AST_OV_TRIP: assert property (ov_hit |-> ##2 !fault_out_n)
        else $error("overvoltage not flagged");
    AST_UV_TRIP: assert property (uv_hit |-> ##2 !fault_out_n)
        else $error("undervoltage not flagged");
    AST_RESET_QUIET: assert property ($rose(nrst) |-> (fault_out_n && !irq) [*2])
        else $error("fault raised out of reset");
    AST_PERMIT_BLOCKED: assert property (!fault_out_n |-> !run_permit)
        else $error("run permitted under fault");
    cover property (pslverr);
    cover property ($fell(fault_out_n));
    cover property ($rose(irq));
endmodule // mfs_chk
bind mfs_supervisor mfs_chk #(.MW(MW)) u_chk (.sys_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .supply_meas, .voltage_base,
    .fault_out_n, .run_permit, .irq);
`default_nettype wire

// ---- testbench/mfs_drive_model.sv ----
// drive stage and sensing model feeding the supervisor
`timescale 1ns/1ps
`default_nettype none
module mfs_drive_model #(parameter MW = 16) (
    input  wire logic          sys_clk,
    output var  logic [MW-1:0] speed_meas,
    output var  logic [MW-1:0] emf_meas,
    output var  logic [MW-1:0] supply_meas,
    output var  logic [MW-1:0] current_meas,
    output wire logic [MW-1:0] speed_max,
    output wire logic [MW-1:0] current_base,
    output wire logic [MW-1:0] voltage_base,
    output wire logic          motor_running
);
    // fixed bases keep every threshold a round figure
    assign speed_max = MW'(1000);
    assign current_base = MW'(1000);
    assign voltage_base = MW'(1000);
    assign motor_running = 1'b1;
    initial begin
        speed_meas = MW'(500);
        emf_meas = MW'(400);
        supply_meas = MW'(500);
        current_meas = MW'(500);
    end
    task set(input int s, input int e, input int v, input int c);
        @(posedge sys_clk);
        speed_meas <= MW'(s);
        emf_meas <= MW'(e);
        supply_meas <= MW'(v);
        current_meas <= MW'(c);
    endtask
endmodule // mfs_drive_model
`default_nettype wire

// ---- testbench/motor_fault_supervisor_tb_top.sv ----
// self-checking bench for the motor fault supervisor
`timescale 1ns/1ps
`default_nettype none
module motor_fault_supervisor_tb_top;
    localparam int TICK = 10;
    logic        sys_clk, pready, pslverr, err, fault_out_n, run_permit, irq, mrun;
    logic        nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, rsv, lfsr = 32'h3F;
    logic [15:0] spd, smax, emf, sup, cur, cbase, vbase;
    int          num_errors = 0, checks_done = 0, n, cnt, i, e;
    int unsigned mdl[int];
    int lim[5] = '{'h00, 'h0D, 'h0E, 'hF0, 'h20};
    int near[5] = '{590, 890, 990, 260, 60};
    int bad[5] = '{700, 950, 1100, 200, 30};
    int auto_clr[5] = '{0, 1, 0, 1, 0};
    int ms[2] = '{100, 500};
    mfs_drive_model u_drv (.sys_clk(sys_clk), .speed_meas(spd), .emf_meas(emf),
        .supply_meas(sup), .current_meas(cur), .speed_max(smax), .current_base(cbase),
        .voltage_base(vbase), .motor_running(mrun));
    mfs_supervisor #(.TICK_CYCLES(TICK)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .speed_meas(spd), .speed_max(smax),
        .emf_meas(emf), .supply_meas(sup), .current_meas(cur), .current_base(cbase),
        .voltage_base(vbase), .motor_running(mrun), .fault_out_n(fault_out_n),
        .run_permit(run_permit), .irq(irq));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin chk(0, 1); conclude; end
        rd = prdata;
        err = pslverr;
        if (w && (a == 8'h54 || a == 8'h58)) mdl[a] = d;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task wait_fo(input logic lvl, input int lim_c);
        cnt = 0;
        while (fault_out_n !== lvl && cnt < lim_c) begin @(posedge sys_clk); cnt++; end
        chk(fault_out_n, lvl);
        if (fault_out_n !== lvl) conclude;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(run_permit, 1);
        rchk(8'h54, 32'h0);
        rchk(8'h58, 32'h0);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk(err, 1);
        rchk(8'h40, 32'h0);
        chk(err, 1);
        for (i = 0; i < 4; i++) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        apb(1'b1, 8'h54, lfsr | 32'h3);
        rchk(8'h54, mdl[8'h54]);
        rsv = lfsr & 32'hF800_1F00;
        apb(1'b1, 8'h58, rsv);
        rchk(8'h58, mdl[8'h58]);
        $display("test registers done");
        for (i = 0; i < 5; i++) begin
            apb(1'b1, 8'h58, lim[i] | rsv);
            u_drv.set(500, 400, near[i], 500);
            repeat (6) @(posedge sys_clk);
            chk(fault_out_n, 1);
            u_drv.set(500, 400, bad[i], 500);
            wait_fo(1'b0, 10);
            u_drv.set(500, 400, 500, 500);
            repeat (6) @(posedge sys_clk);
            chk(fault_out_n, auto_clr[i]);
            rchk(8'h5C, (i < 3) ? 32'h4 : 32'h2);
            if (auto_clr[i] == 0) apb(1'b1, 8'h68, 32'h1);
            wait_fo(1'b1, 10);
            apb(1'b1, 8'h60, 32'hF);
        end
        $display("test supply limits done");
        apb(1'b1, 8'h54, 32'h2);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, 8'h58, rsv);
            apb(1'b1, 8'h64, (i != 2) ? 32'h1 : 32'h0);
            u_drv.set((i == 0) ? 1600 : 500, (i == 1) ? 2 : 400, 500, (i == 2) ? 10 : 500);
            repeat (6) @(posedge sys_clk);
            rchk(8'h5C, 32'h0);
            apb(1'b1, 8'h58, (32'h1 << (26 - i)) | rsv);
            repeat (6) @(posedge sys_clk);
            chk(fault_out_n, 1);
            chk(irq, (i != 2) ? 1 : 0);
            rchk(8'h5C, 32'h1);
            u_drv.set(500, 400, 500, 500);
            apb(1'b1, 8'h60, 32'h1);
            repeat (3) @(posedge sys_clk);
            chk(irq, 0);
        end
        $display("test lock checks done");
        apb(1'b1, 8'h54, 32'h3);
        // overspeed check must be on, or the lock tests below never trip
        apb(1'b1, 8'h58, 32'h0400_0000 | rsv);
        u_drv.set(1600, 400, 500, 500);
        repeat (6) @(posedge sys_clk);
        rchk(8'h5C, 32'h0);
        apb(1'b1, 8'h54, 32'h0);
        wait_fo(1'b0, 10);
        u_drv.set(500, 400, 500, 500);
        repeat (6) @(posedge sys_clk);
        chk(fault_out_n, 0);
        apb(1'b1, 8'h68, 32'h1);
        wait_fo(1'b1, 10);
        apb(1'b1, 8'h60, 32'hF);
        $display("test lock latch done");
        for (i = 0; i < 2; i++) begin
            apb(1'b1, 8'h54, (i << 2) | 1);
            u_drv.set(1600, 400, 500, 500);
            wait_fo(1'b0, 10);
            u_drv.set(500, 400, 500, 500);
            e = ms[i] * TICK;
            wait_fo(1'b1, 2 * e);
            chk(cnt > e - 30 && cnt < e + 30, 1);
            repeat (2) @(posedge sys_clk);
            chk(run_permit, 1);
            rchk(8'h5C, 32'h9);
            apb(1'b1, 8'h60, 32'hF);
        end
        $display("test lock retry done");
        conclude;
    end
endmodule // motor_fault_supervisor_tb_top
`default_nettype wire
